// file: logic/serial_in_parallel_out_latch.sv
`timescale 1ns/1ps
// Functional notes
// R1 - Eight-stage serial-in shift register feeds storage.
// R2 - Eight-bit storage register drives three-state outputs.
// R3 - Shift and storage registers have separate clocks.
// R4 - Only rising clock edges change state.
// R5 - First stage takes serial input on shift edge.
// R6 - Other stages take previous stage value.
// R7 - Low clear zeroes shift register asynchronously.
// R8 - Storage edge copies all stages, ungated.
// R9 - High output enable floats parallel outputs.
// R10 - Last stage drives cascade serial output.
// R11 - Cascade output is always driven.
// R12 - Tied clocks: storage trails shift by one.
// R13 - Clear leaves storage untouched until store edge.
// R14 - Host shifts eight bits then one store edge.
module serial_in_parallel_out_latch (
    input wire logic clk_in,
    input wire logic reset_in,
    input wire latch_pkg::pin_in_t pins_in,
    output logic [latch_pkg::STAGES-1:0] parallel_out,
    output logic [latch_pkg::STAGES-1:0] parallel_oe_out,
    output logic cascade_serial_out
);
    import latch_pkg::*;

    // Two-flop synchronisers plus one history stage per clock pin.
    logic [2:0] shift_clk_sync_ff, nxt_shift_clk_sync;
    logic [2:0] store_clk_sync_ff, nxt_store_clk_sync;
    logic [1:0] data_sync_ff, nxt_data_sync;
    logic [1:0] oe_n_sync_ff, nxt_oe_n_sync;
    logic clear_meta_ff, nxt_clear_meta;
    logic clear_n_ff, nxt_clear_n;
    logic [STAGES-1:0] shift_ff, nxt_shift;
    logic [STAGES-1:0] store_ff, nxt_store;
    logic [STAGES-1:0] parallel_ff, nxt_parallel;
    logic [STAGES-1:0] oe_ff, nxt_oe;
    logic cascade_ff, nxt_cascade;
    logic shift_rise, store_rise;

    function automatic logic rising(input logic [2:0] s);
        rising = s[1] && !s[2];
    endfunction : rising

    always_comb begin
        nxt_shift_clk_sync = {shift_clk_sync_ff[1:0], pins_in.shift_clock};
        nxt_store_clk_sync = {store_clk_sync_ff[1:0], pins_in.store_clock};
        nxt_data_sync = {data_sync_ff[0], pins_in.serial_data};
        nxt_oe_n_sync = {oe_n_sync_ff[0], pins_in.output_enable_n};
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            shift_clk_sync_ff <= SYNC_RESET;
            store_clk_sync_ff <= SYNC_RESET;
            data_sync_ff <= DATA_SYNC_RESET;
            oe_n_sync_ff <= OE_N_SYNC_RESET;
        end else begin
            shift_clk_sync_ff <= nxt_shift_clk_sync;
            store_clk_sync_ff <= nxt_store_clk_sync;
            data_sync_ff <= nxt_data_sync;
            oe_n_sync_ff <= nxt_oe_n_sync;
        end
    end

    always_comb begin
        nxt_clear_meta = 1'b1;
        nxt_clear_n = clear_meta_ff;
    end

    // Clear is asserted asynchronously, released through two flops.
    always_ff @(posedge clk_in or negedge pins_in.shift_clear_n or posedge reset_in) begin
        if (reset_in || !pins_in.shift_clear_n) begin
            clear_meta_ff <= CLEAR_SYNC_RESET;
            clear_n_ff <= CLEAR_SYNC_RESET;
        end else begin
            clear_meta_ff <= nxt_clear_meta;
            clear_n_ff <= nxt_clear_n;
        end
    end

    assign shift_rise = rising(shift_clk_sync_ff); // R4 R3
    assign store_rise = rising(store_clk_sync_ff); // R4 R3

    // Shift group: serial input enters stage 0 and the cascade mirrors the last stage.
    always_comb begin
        nxt_shift = shift_ff;
        if (shift_rise) begin
            nxt_shift = {shift_ff[STAGES-2:0], data_sync_ff[1]}; // R1 R5 R6
        end
        nxt_cascade = nxt_shift[STAGES-1]; // R10
    end

    always_ff @(posedge clk_in or posedge reset_in or negedge pins_in.shift_clear_n) begin
        if (reset_in || !pins_in.shift_clear_n) begin
            shift_ff <= SHIFT_RESET; // R7
            cascade_ff <= CASCADE_RESET;
        end else if (!clear_n_ff) begin
            shift_ff <= SHIFT_RESET; // R7
            cascade_ff <= CASCADE_RESET;
        end else begin
            shift_ff <= nxt_shift;
            cascade_ff <= nxt_cascade;
        end
    end

    // Storage group: a storage edge copies every stage, ungated by clear or enable.
    always_comb begin
        nxt_store = store_ff;
        if (store_rise) begin
            nxt_store = shift_ff; // R8 R12 R13
        end
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            store_ff <= STORE_RESET;
        end else begin
            store_ff <= nxt_store;
        end
    end

    // Output group: data and enables leave straight from flops.
    always_comb begin
        nxt_parallel = nxt_store; // R2
        nxt_oe = {STAGES{!oe_n_sync_ff[1]}}; // R9
    end

    always_ff @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            parallel_ff <= STORE_RESET;
            oe_ff <= OE_RESET;
        end else begin
            parallel_ff <= nxt_parallel;
            oe_ff <= nxt_oe;
        end
    end

    assign parallel_out = parallel_ff;
    assign parallel_oe_out = oe_ff;
    assign cascade_serial_out = cascade_ff; // R11

    a_shift_moves: assert property ( // R6
        @(posedge clk_in) disable iff (reset_in || !clear_n_ff)
        shift_rise && clear_n_ff && pins_in.shift_clear_n
        |=> shift_ff[STAGES-1:1] == $past(shift_ff[STAGES-2:0]) || !pins_in.shift_clear_n
    ) else begin
        $error("shift did not move");
    end

    a_first_stage: assert property ( // R5
        @(posedge clk_in) disable iff (reset_in)
        shift_rise && clear_n_ff && pins_in.shift_clear_n
        |=> shift_ff[0] == $past(data_sync_ff[1]) || !pins_in.shift_clear_n
    ) else begin
        $error("first stage wrong");
    end

    a_shift_hold: assert property ( // R4
        @(posedge clk_in) disable iff (reset_in)
        !shift_rise && clear_n_ff && pins_in.shift_clear_n
        |=> $stable(shift_ff) || !pins_in.shift_clear_n
    ) else begin
        $error("shift changed without edge");
    end

    a_clear_zero: assert property ( // R7
        @(posedge clk_in) disable iff (reset_in)
        !clear_n_ff
        |-> shift_ff == SHIFT_RESET
    ) else begin
        $error("clear did not zero");
    end

    a_clear_cascade: assert property ( // R7
        @(posedge clk_in) disable iff (reset_in)
        !clear_n_ff
        |-> cascade_serial_out == CASCADE_RESET
    ) else begin
        $error("clear did not zero cascade");
    end

    a_clear_async: assert property ( // R7
        @(posedge clk_in) disable iff (reset_in)
        !pins_in.shift_clear_n
        |-> shift_ff == SHIFT_RESET && cascade_serial_out == CASCADE_RESET
    ) else begin
        $error("clear pin did not zero at once");
    end

    a_store_copy: assert property ( // R8
        @(posedge clk_in) disable iff (reset_in)
        store_rise
        |=> store_ff == $past(shift_ff)
    ) else begin
        $error("store copy wrong");
    end

    a_store_hold: assert property ( // R13
        @(posedge clk_in) disable iff (reset_in)
        !store_rise
        |=> $stable(store_ff)
    ) else begin
        $error("store changed without edge");
    end

    a_clear_keeps_store: assert property ( // R13
        @(posedge clk_in) disable iff (reset_in)
        !pins_in.shift_clear_n && !store_rise
        |=> $stable(parallel_out)
    ) else begin
        $error("clear disturbed outputs");
    end

    a_out_follow: assert property ( // R2
        @(posedge clk_in) disable iff (reset_in)
        store_rise
        |=> parallel_out == $past(shift_ff)
    ) else begin
        $error("outputs not storage");
    end

    a_oe_float: assert property ( // R9
        @(posedge clk_in) disable iff (reset_in)
        oe_n_sync_ff[1]
        |=> parallel_oe_out == '0
    ) else begin
        $error("outputs not floated");
    end

    a_oe_drive: assert property ( // R9
        @(posedge clk_in) disable iff (reset_in)
        !oe_n_sync_ff[1]
        |=> parallel_oe_out == '1
    ) else begin
        $error("outputs not driven");
    end

    a_oe_keeps_data: assert property ( // R9
        @(posedge clk_in) disable iff (reset_in)
        $changed(oe_n_sync_ff[1]) && !store_rise
        |=> $stable(parallel_out)
    ) else begin
        $error("enable change altered data");
    end

    a_cascade_last: assert property ( // R10
        @(posedge clk_in) disable iff (reset_in)
        1'b1
        |-> cascade_serial_out == shift_ff[STAGES-1]
    ) else begin
        $error("cascade not last stage");
    end

    a_cascade_free: assert property ( // R11
        @(posedge clk_in) disable iff (reset_in)
        $changed(oe_n_sync_ff[1]) && !shift_rise && clear_n_ff && pins_in.shift_clear_n
        |=> $stable(cascade_serial_out) || !pins_in.shift_clear_n
    ) else begin
        $error("cascade followed enable");
    end

    a_store_no_shift: assert property ( // R3
        @(posedge clk_in) disable iff (reset_in)
        store_rise && !shift_rise && clear_n_ff && pins_in.shift_clear_n
        |=> $stable(shift_ff) || !pins_in.shift_clear_n
    ) else begin
        $error("storage edge moved shift");
    end

    a_shift_no_store: assert property ( // R3
        @(posedge clk_in) disable iff (reset_in)
        shift_rise && !store_rise
        |=> $stable(parallel_out)
    ) else begin
        $error("shift edge moved outputs");
    end

    a_tied_trail: assert property ( // R12
        @(posedge clk_in) disable iff (reset_in || !clear_n_ff)
        shift_rise && store_rise
        |=> store_ff == $past(shift_ff)
    ) else begin
        $error("tied clocks wrong");
    end

    c_shift: cover property (
        @(posedge clk_in) disable iff (reset_in)
        shift_rise
    );
    c_store: cover property (
        @(posedge clk_in) disable iff (reset_in)
        store_rise
    );
    c_tied: cover property (
        @(posedge clk_in) disable iff (reset_in)
        shift_rise && store_rise
    );
    c_clear: cover property (
        @(posedge clk_in) disable iff (reset_in)
        $fell(clear_n_ff)
    );
    c_float: cover property (
        @(posedge clk_in) disable iff (reset_in)
        $rose(oe_n_sync_ff[1])
    );
endmodule : serial_in_parallel_out_latch

// file: shared/latch_pkg.sv
package latch_pkg;
    localparam int STAGES = 8;
    localparam logic [STAGES-1:0] SHIFT_RESET = 8'h00;
    localparam logic [STAGES-1:0] STORE_RESET = 8'h00;
    localparam logic [2:0] SYNC_RESET = 3'h0;
    localparam logic CLEAR_SYNC_RESET = 1'b0;
    localparam logic [1:0] DATA_SYNC_RESET = 2'h0;
    localparam logic [1:0] OE_N_SYNC_RESET = 2'h3;
    localparam logic [STAGES-1:0] OE_RESET = 8'h00;
    localparam logic CASCADE_RESET = 1'b0;

    typedef struct packed {
        logic shift_clock;
        logic store_clock;
        logic serial_data;
        logic shift_clear_n;
        logic output_enable_n;
    } pin_in_t;

    typedef struct packed {
        logic [STAGES-1:0] data;
        logic [STAGES-1:0] enable;
    } par_out_t;
endpackage : latch_pkg

// file: tb/pin_host.sv
`timescale 1ns/1ps
module pin_host (
    output latch_pkg::pin_in_t pins_out,
    input wire logic clk_in
);
    import latch_pkg::*;
    initial pins_out = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
    task automatic hold_pins();
        repeat (5) @(negedge clk_in);
    endtask : hold_pins
    task automatic set_enable_n(input logic level);
        pins_out.output_enable_n = level;
    endtask : set_enable_n
    task automatic set_clear_n(input logic level);
        pins_out.shift_clear_n = level;
    endtask : set_clear_n
    task automatic set_data(input logic level);
        pins_out.serial_data = level;
    endtask : set_data
    // Raises the chosen clocks for five clk_in cycles, then drops them for five more.
    task automatic pulse(input logic shift, input logic store);
        pins_out.shift_clock = shift;
        pins_out.store_clock = store;
        hold_pins();
        pins_out.shift_clock = 1'b0;
        pins_out.store_clock = 1'b0;
        hold_pins();
    endtask : pulse
    task automatic send_byte(input logic [STAGES-1:0] value);
        for (int i = STAGES - 1; i >= 0; i--) begin
            pins_out.serial_data = value[i];
            hold_pins();
            pulse(1'b1, 1'b0);
        end
        pins_out.serial_data = ~value[0];
        pulse(1'b0, 1'b1);
    endtask : send_byte
endmodule : pin_host

// file: tb/test_serial_in_parallel_out_latch.sv
`timescale 1ns/1ps
module test_serial_in_parallel_out_latch;
    import latch_pkg::*;
    logic clk_in = 1'b0;
    logic reset_in = 1'b1;
    pin_in_t pins;
    logic [STAGES-1:0] par;
    logic [STAGES-1:0] oe;
    logic cascade;
    int mismatches = 0;
    int checks_done = 0;
    initial forever #2.5 clk_in = ~clk_in;
    pin_host pin_host_inst (.pins_out(pins), .clk_in(clk_in));
    serial_in_parallel_out_latch serial_in_parallel_out_latch_inst (.clk_in(clk_in), .reset_in(reset_in),
        .pins_in(pins), .parallel_out(par), .parallel_oe_out(oe), .cascade_serial_out(cascade));
    task automatic check(input logic [STAGES-1:0] got, input logic [STAGES-1:0] want);
        checks_done++;
        if (got !== want) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
        end
    endtask : check
    task automatic settle();
        repeat (10) @(negedge clk_in);
    endtask : settle
    task automatic load_and_show();
        pin_host_inst.set_enable_n(1'b0);
        pin_host_inst.send_byte(8'ha5);
        settle();
        check(par, 8'ha5);
        check(oe, 8'hff);
        check({7'h00, cascade}, 8'h01);
    endtask : load_and_show
    task automatic float_outputs();
        pin_host_inst.set_enable_n(1'b1);
        settle();
        check(oe, 8'h00);
        check({7'h00, cascade}, 8'h01);
    endtask : float_outputs
    task automatic clear_shift();
        pin_host_inst.set_clear_n(1'b0);
        settle();
        check({7'h00, cascade}, 8'h00);
        check(par, 8'ha5);
        pin_host_inst.pulse(1'b0, 1'b1);
        settle();
        check(par, 8'h00);
        pin_host_inst.set_clear_n(1'b1);
        settle();
    endtask : clear_shift
    task automatic tied_clocks();
        pin_host_inst.set_data(1'b1);
        pin_host_inst.hold_pins();
        pin_host_inst.pulse(1'b1, 1'b1);
        settle();
        check(par, 8'h00);
        pin_host_inst.pulse(1'b1, 1'b1);
        settle();
        check(par, 8'h01);
    endtask : tied_clocks
    task automatic close_out();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (8) @(negedge clk_in);
        reset_in = 1'b0;
        repeat (2) @(negedge clk_in);
        load_and_show();
        float_outputs();
        clear_shift();
        tied_clocks();
        close_out();
    end
endmodule : test_serial_in_parallel_out_latch
